/* logic/sdmr_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
`include "sdmr_cfg.svh"
module sdmr_ctrl #(
    parameter int unsigned PWRUP_CYC = `SD_PWRUP_CYC
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic sd_cke,
    output logic sd_cs_n,
    output logic sd_ras_n,
    output logic sd_cas_n,
    output logic sd_we_n,
    output logic [11:0] sd_addr,
    output logic [1:0] sd_ba,
    output logic sd_dqm,
    output logic [15:0] sd_dq_out,
    output logic sd_dq_oe,
    input wire logic [15:0] sd_dq_in
);
    // ***********************************************************
    // constants in cycles
    // ***********************************************************
    localparam logic [3:0] TRC_C = 4'(`SD_TRC_CYC);
    localparam logic [3:0] ROW_ACTIVE_TIME_C = 4'(`SD_ROW_ACTIVE_TIME_CYC);
    localparam logic [3:0] TRCD_C = 4'(`SD_TRCD_CYC);
    localparam logic [3:0] TRP_C = 4'(`SD_TRP_CYC);
    localparam logic [3:0] MRD_C = 4'(`SD_TMRD_CYC);
    localparam logic [3:0] EXIT_C = 4'(`SD_EXIT_CYC);
    localparam logic [3:0] CL_C = 4'(`SD_CL_CYC);
    localparam logic [13:0] REF_C = 14'(`SD_REF_CYC);

    // ***********************************************************
    // state and registers
    // ***********************************************************
    sdmr_pkg::sdmr_state_type state_r, state_nxt, ret_r, ret_nxt;
    logic [3:0] cmd_r, cmd_nxt;
    logic cke_r, cke_nxt;
    logic [11:0] addr_r, addr_nxt;
    logic [1:0] ba_r, ba_nxt;
    logic [4:0] cfg_r;
    logic [21:0] acc_r;
    logic [15:0] wdata_r, rdata_r, dq_out_r;
    logic [6:0] req_r, take;
    logic dir_r, rvalid_r, ref_pend_r, mrs_done_r, mrs_nxt;
    logic [1:0] init_cnt_r, init_nxt;
    logic [3:0] rd_cnt_r, wr_left_r;
    logic dq_oe_r, wload, wait_zero, ref_tick, ref_clr;
    logic [13:0] wval;

    // ***********************************************************
    // decoding
    // ***********************************************************
    wire wr_cfg = reg_wr && (reg_addr == `SD_REG_CFG);
    wire wr_cmd = reg_wr && (reg_addr == `SD_REG_CMD);
    wire wr_acc = reg_wr && (reg_addr == `SD_REG_ADDR);
    wire wr_dat = reg_wr && (reg_addr == `SD_REG_WDATA);
    wire rd_dat = reg_rd && (reg_addr == `SD_REG_RDATA);
    wire [6:0] req_set = wr_cmd ? (reg_wdata[6:0] & `SD_REQ_MASK) : 7'h0;
    wire [3:0] bl = 4'h1 << cfg_r[1:0];
    wire [3:0] beats = cfg_r[`SD_CFG_SW] ? 4'h1 : bl;
    // stretch activate-to-column so auto precharge starts late enough
    wire [3:0] act_gap = (ROW_ACTIVE_TIME_C > TRCD_C + bl) ? ROW_ACTIVE_TIME_C - bl : TRCD_C;
    // mode word: test bit and reserved bits forced low
    wire [11:0] mode_word = {2'h0, cfg_r[`SD_CFG_SW], 2'h0,
        `SD_CAS_CODE, cfg_r[`SD_CFG_IL], 1'b0, cfg_r[1:0]}; // [RULE3][RULE4][RULE5]
    wire capture = (rd_cnt_r == 4'h1);
    wire [31:0] status = {26'h0, ref_pend_r, rvalid_r,
        state_r == sdmr_pkg::st_pd, state_r == sdmr_pkg::st_self,
        state_r != sdmr_pkg::st_idle, mrs_done_r};
    wire [31:0] rd_mux =
        (reg_addr == `SD_REG_CFG) ? {27'h0, cfg_r} :
        (reg_addr == `SD_REG_ADDR) ? {10'h0, acc_r} :
        (reg_addr == `SD_REG_WDATA) ? {16'h0, wdata_r} :
        (reg_addr == `SD_REG_RDATA) ? {16'h0, rdata_r} :
        (reg_addr == `SD_REG_STATUS) ? status : 32'h0;

    // pins from flops, sd_dqm tied low
    assign {sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n} = cmd_r;
    assign sd_cke = cke_r;
    assign sd_addr = addr_r;
    assign sd_ba = ba_r;
    assign sd_dqm = 1'b0;
    assign sd_dq_out = dq_out_r;
    assign sd_dq_oe = dq_oe_r;
    assign ref_clr = (cmd_nxt == `SD_CMD_REF);

    // ***********************************************************
    // timers: refresh interval and command spacing
    // ***********************************************************
    sdmr_timer u_ref (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(ref_tick),
        .load_val(REF_C - 14'h1),
        .zero(ref_tick)
    ); // [RULE8][RULE22]

    sdmr_timer u_wait (
        .clk(clk),
        .sys_rst(sys_rst),
        .load(wload),
        .load_val(wval),
        .zero(wait_zero)
    );

    // ***********************************************************
    // command sequencer
    // ***********************************************************
    always_comb
    begin
        state_nxt = state_r;
        ret_nxt = ret_r;
        cmd_nxt = `SD_CMD_NOP;
        cke_nxt = cke_r;
        addr_nxt = 12'h0;
        ba_nxt = 2'h0;
        wload = 1'b0;
        wval = 14'h0;
        take = 7'h0;
        init_nxt = init_cnt_r;
        mrs_nxt = mrs_done_r;
        case (state_r)
            sdmr_pkg::st_pwrup:
            begin
                cke_nxt = 1'b1;
                wload = 1'b1;
                wval = 14'(PWRUP_CYC);
                ret_nxt = sdmr_pkg::st_ipre;
                state_nxt = sdmr_pkg::st_wait;
            end
            sdmr_pkg::st_ipre:
            begin
                cmd_nxt = `SD_CMD_PRE;
                addr_nxt = `SD_ADDR_ALL;
                wload = 1'b1;
                wval = 14'(TRP_C - 4'h2);
                ret_nxt = sdmr_pkg::st_iref;
                state_nxt = sdmr_pkg::st_wait;
            end
            sdmr_pkg::st_iref:
            begin
                cmd_nxt = `SD_CMD_REF;
                init_nxt = init_cnt_r + 2'h1;
                wload = 1'b1;
                wval = 14'(TRC_C - 4'h2); // [RULE9]
                ret_nxt = (init_cnt_r == 2'(`SD_INIT_REFS - 1)) ?
                    sdmr_pkg::st_mrs : sdmr_pkg::st_iref;
                state_nxt = sdmr_pkg::st_wait;
            end
            sdmr_pkg::st_mrs:
            begin
                // only reached with every bank closed
                cmd_nxt = `SD_CMD_MRS; // [RULE19]
                addr_nxt = mode_word;
                mrs_nxt = 1'b1;
                take[`SD_REQ_MRS] = 1'b1;
                wload = 1'b1;
                wval = 14'(MRD_C - 4'h2);
                ret_nxt = sdmr_pkg::st_idle;
                state_nxt = sdmr_pkg::st_wait;
            end
            sdmr_pkg::st_wait:
            begin
                if (wait_zero)
                    state_nxt = ret_r;
            end
            sdmr_pkg::st_idle:
            begin
                if (ref_pend_r)
                begin
                    // close banks first, activates wait behind it
                    cmd_nxt = `SD_CMD_PRE; // [RULE22][RULE7]
                    addr_nxt = `SD_ADDR_ALL;
                    wload = 1'b1;
                    wval = 14'(TRP_C - 4'h2);
                    ret_nxt = sdmr_pkg::st_ref;
                    state_nxt = sdmr_pkg::st_wait;
                end
                else if (req_r[`SD_REQ_MRS])
                    state_nxt = sdmr_pkg::st_mrs;
                else if (req_r[`SD_REQ_SRE])
                begin
                    cmd_nxt = `SD_CMD_REF; // [RULE10]
                    cke_nxt = 1'b0;
                    take[`SD_REQ_SRE] = 1'b1;
                    state_nxt = sdmr_pkg::st_self;
                end
                else if (req_r[`SD_REQ_PDE])
                begin
                    cke_nxt = 1'b0;
                    take[`SD_REQ_PDE] = 1'b1;
                    state_nxt = sdmr_pkg::st_pd;
                end
                else if (req_r[`SD_REQ_GO])
                begin
                    cmd_nxt = `SD_CMD_ACT;
                    ba_nxt = acc_r[21:20];
                    addr_nxt = acc_r[19:8];
                    wload = 1'b1;
                    wval = 14'(act_gap - 4'h2); // [RULE17]
                    ret_nxt = sdmr_pkg::st_rw;
                    state_nxt = sdmr_pkg::st_wait;
                end
            end
            sdmr_pkg::st_ref:
            begin
                cmd_nxt = `SD_CMD_REF; // [RULE7]
                wload = 1'b1;
                wval = 14'(TRC_C - 4'h2); // [RULE9]
                ret_nxt = sdmr_pkg::st_idle;
                state_nxt = sdmr_pkg::st_wait;
            end
            sdmr_pkg::st_rw:
            begin
                cmd_nxt = dir_r ? `SD_CMD_WRITE : `SD_CMD_READ;
                ba_nxt = acc_r[21:20];
                addr_nxt = `SD_ADDR_ALL | {4'h0, acc_r[7:0]};
                take[`SD_REQ_GO] = 1'b1;
                wload = 1'b1;
                wval = 14'(bl + CL_C + TRP_C - 4'h1);
                ret_nxt = sdmr_pkg::st_idle;
                state_nxt = sdmr_pkg::st_wait;
            end
            sdmr_pkg::st_self:
            begin
                if (req_r[`SD_REQ_SRX])
                begin
                    cke_nxt = 1'b1; // [RULE13]
                    take[`SD_REQ_SRX] = 1'b1;
                    wload = 1'b1;
                    wval = 14'(EXIT_C + TRC_C - 4'h2); // [RULE18]
                    ret_nxt = sdmr_pkg::st_idle;
                    state_nxt = sdmr_pkg::st_wait;
                end
            end
            sdmr_pkg::st_pd:
            begin
                // a due refresh also pulls the device out
                if (req_r[`SD_REQ_PDX] || ref_pend_r)
                begin
                    cke_nxt = 1'b1; // [RULE13]
                    take[`SD_REQ_PDX] = 1'b1;
                    wload = 1'b1;
                    wval = 14'(EXIT_C); // [RULE18]
                    ret_nxt = sdmr_pkg::st_idle;
                    state_nxt = sdmr_pkg::st_wait;
                end
            end
            default:
                state_nxt = sdmr_pkg::st_idle;
        endcase
    end

    // ***********************************************************
    // flops
    // ***********************************************************
    // sequencer and pins
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_r <= sdmr_pkg::st_pwrup;
            ret_r <= sdmr_pkg::st_idle;
            cmd_r <= `SD_CMD_NOP;
            cke_r <= 1'b0;
            addr_r <= 12'h0;
            ba_r <= 2'h0;
            init_cnt_r <= 2'h0;
            mrs_done_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            ret_r <= ret_nxt;
            cmd_r <= cmd_nxt;
            cke_r <= cke_nxt;
            addr_r <= addr_nxt;
            ba_r <= ba_nxt;
            init_cnt_r <= init_nxt;
            mrs_done_r <= mrs_nxt;
        end
    end

    // software registers; a new set beats a same-cycle take
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cfg_r <= `SD_CFG_RST;
            acc_r <= 22'h0;
            wdata_r <= 16'h0;
            req_r <= 7'h0;
            dir_r <= 1'b0;
            reg_rdata <= 32'h0;
            ref_pend_r <= 1'b0;
        end
        else
        begin
            if (wr_cfg)
                cfg_r <= reg_wdata[4:0];
            if (wr_acc)
                acc_r <= reg_wdata[21:0];
            if (wr_dat)
                wdata_r <= reg_wdata[15:0];
            if (wr_cmd && reg_wdata[`SD_REQ_GO])
                dir_r <= reg_wdata[`SD_REQ_DIR];
            req_r <= (req_r & ~take) | req_set;
            reg_rdata <= reg_rd ? rd_mux : 32'h0;
            ref_pend_r <= ref_tick | (ref_pend_r & ~ref_clr); // [RULE8]
        end
    end

    // data path: write beats out, first read word in
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rd_cnt_r <= 4'h0;
            wr_left_r <= 4'h0;
            dq_oe_r <= 1'b0;
            dq_out_r <= 16'h0;
            rdata_r <= 16'h0;
            rvalid_r <= 1'b0;
        end
        else
        begin
            if (cmd_nxt == `SD_CMD_READ)
                rd_cnt_r <= CL_C + 4'h1;
            else if (rd_cnt_r != 4'h0)
                rd_cnt_r <= rd_cnt_r - 4'h1;
            if (cmd_nxt == `SD_CMD_WRITE)
            begin
                wr_left_r <= beats - 4'h1;
                dq_oe_r <= 1'b1;
                dq_out_r <= wdata_r;
            end
            else if (wr_left_r != 4'h0)
                wr_left_r <= wr_left_r - 4'h1;
            else
                dq_oe_r <= 1'b0;
            if (capture)
                rdata_r <= sd_dq_in;
            rvalid_r <= capture | (rvalid_r & ~rd_dat);
        end
    end

    // ***********************************************************
    // checks
    // ***********************************************************
    logic [10:0] since_ref_r;
    logic [3:0] act_age_r, pre_age_r;

    // ages since refresh, activate and precharge
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            since_ref_r <= 11'h0;
            act_age_r <= 4'h0;
            pre_age_r <= 4'h0;
        end
        else
        begin
            if (cmd_r == `SD_CMD_REF || state_r == sdmr_pkg::st_self)
                since_ref_r <= 11'h0;
            else if (since_ref_r != 11'h7ff)
                since_ref_r <= since_ref_r + 11'h1;
            act_age_r <= (cmd_r == `SD_CMD_ACT) ? 4'h1 :
                (act_age_r == 4'hf) ? act_age_r : act_age_r + 4'h1;
            pre_age_r <= (cmd_r == `SD_CMD_PRE) ? 4'h1 :
                (pre_age_r == 4'hf) ? pre_age_r : pre_age_r + 4'h1;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_mrs_latency: // [RULE3]
    assert property (cmd_r == `SD_CMD_MRS |-> sd_addr[6:4] == `SD_CAS_CODE)
    else $error("mode load latency field wrong");
    a_mrs_test_bit: // [RULE4]
    assert property (cmd_r == `SD_CMD_MRS |-> !sd_addr[7])
    else $error("mode load sets test bit");
    a_mrs_reserved: // [RULE5]
    assert property (cmd_r == `SD_CMD_MRS |->
        sd_addr[11:10] == 2'h0 && !sd_addr[8] && sd_ba == 2'h0)
    else $error("mode load reserved bits set");
    // banks closed by a later precharge or a finished auto precharge
    a_ref_banks_idle: // [RULE7]
    assert property (cmd_r == `SD_CMD_REF && $past(sd_cke) |->
        (pre_age_r >= TRP_C && act_age_r > pre_age_r) ||
        act_age_r > TRCD_C + bl + TRP_C)
    else $error("refresh with a bank possibly open");
    a_ref_interval: // [RULE8]
    assert property (mrs_done_r |-> since_ref_r <= 11'(REF_C + 14'h40))
    else $error("refresh interval exceeded");
    a_ref_gap: // [RULE9]
    assert property (cmd_r == `SD_CMD_REF |=> cmd_r == `SD_CMD_NOP [*4])
    else $error("command inside row cycle time");
    a_self_entry: // [RULE10]
    assert property (cmd_r == `SD_CMD_REF && !sd_cke |->
        $past(sd_cke) && state_r == sdmr_pkg::st_self)
    else $error("self refresh entry malformed");
    a_exit_nop: // [RULE13]
    assert property ($rose(sd_cke) |->
        cmd_r == `SD_CMD_NOP ##1 cmd_r == `SD_CMD_NOP)
    else $error("no nop after clock enable rise");
    a_act_spacing: // [RULE17]
    assert property ((cmd_r == `SD_CMD_READ || cmd_r == `SD_CMD_WRITE) |->
        act_age_r >= TRCD_C && act_age_r + bl >= ROW_ACTIVE_TIME_C)
    else $error("activate too close to auto precharge");
    a_act_after_mrs: // [RULE19]
    assert property (cmd_r == `SD_CMD_ACT |-> mrs_done_r)
    else $error("activate before mode load");

    c_read: cover property (capture);
    c_write: cover property (cmd_r == `SD_CMD_WRITE);
    c_self: cover property (state_r == sdmr_pkg::st_self ##1 $rose(sd_cke));
    c_pd: cover property (state_r == sdmr_pkg::st_pd);
    c_refresh: cover property (cmd_r == `SD_CMD_REF && mrs_done_r);
endmodule : sdmr_ctrl
`default_nettype wire

/* logic/sdmr_cfg.svh */
// Notes on behaviour
// [RULE1] device orders interleaved burst columns by xor
// [RULE2] device read latency from mode bits six-four
// [RULE3] program smallest latency covering column access time
// [RULE4] mode bit seven always written zero
// [RULE5] reserved mode bits and bank bits zero
// [RULE6] device mode bit nine selects single write
// [RULE7] auto refresh only with all banks idle
// [RULE8] 4096 row refreshes within every 64 ms
// [RULE9] wait row cycle time after auto refresh
// [RULE10] self refresh: refresh command with clock enable low
// [RULE11] device holds self refresh while enable low
// [RULE12] device power-down while enable low, no burst
// [RULE13] no-operation at edge after enable rises
// [RULE14] device freezes burst while enable low
// [RULE15] device read mask disables outputs two later
// [RULE16] device write mask blocks same-cycle word
// [RULE17] activate spaced so precharge follows row active time
// [RULE18] allow setup plus one clock after enable rises
// [RULE19] mode load only idle, before normal operation
// [RULE20] device burst length from mode bits two-zero
// [RULE21] device order select bit three, full page sequential
// [RULE22] refresh interval counter, close banks, hold activates
`ifndef SDMR_CFG_SVH
`define SDMR_CFG_SVH

// ***********************************************************
// timing figures in ns, and the refresh row count
// ***********************************************************
`define SD_TCK_NS 20
`define SD_TRC_NS 84
`define SD_ROW_ACTIVE_TIME_NS 60
`define SD_TRCD_NS 30
`define SD_TRP_NS 30
`define SD_COLUMN_ACCESS_TIME_NS 25
`define SD_CLOCK_GATE_SETUP_TIME_NS 3
`define SD_TCKMIN_NS 10
`define SD_PWRUP_NS 200000
`define SD_REF_WIN_NS 64000000
`define SD_REF_ROWS 4096

// ***********************************************************
// derived cycle counts
// ***********************************************************
`define SD_CEIL(ns) (((ns) + `SD_TCK_NS - 1) / `SD_TCK_NS)
`define SD_TRC_CYC `SD_CEIL(`SD_TRC_NS)
`define SD_ROW_ACTIVE_TIME_CYC `SD_CEIL(`SD_ROW_ACTIVE_TIME_NS)
`define SD_TRCD_CYC `SD_CEIL(`SD_TRCD_NS)
`define SD_TRP_CYC `SD_CEIL(`SD_TRP_NS)
`define SD_TMRD_CYC 2
`define SD_EXIT_CYC `SD_CEIL(`SD_CLOCK_GATE_SETUP_TIME_NS + `SD_TCKMIN_NS)
`define SD_CL_RAW `SD_CEIL(`SD_COLUMN_ACCESS_TIME_NS)
`define SD_CL_CYC ((`SD_CL_RAW < 2) ? 2 : `SD_CL_RAW)
`define SD_CAS_CODE ((`SD_CL_CYC == 2) ? 3'h2 : 3'h3)
`define SD_REF_CYC (`SD_REF_WIN_NS / `SD_REF_ROWS / `SD_TCK_NS)
`define SD_PWRUP_CYC (`SD_PWRUP_NS / `SD_TCK_NS)
`define SD_INIT_REFS 2

// ***********************************************************
// commands as {cs_n, ras_n, cas_n, we_n}
// ***********************************************************
`define SD_CMD_NOP 4'h7
`define SD_CMD_ACT 4'h3
`define SD_CMD_READ 4'h5
`define SD_CMD_WRITE 4'h4
`define SD_CMD_PRE 4'h2
`define SD_CMD_REF 4'h1
`define SD_CMD_MRS 4'h0
`define SD_ADDR_ALL 12'h400

// ***********************************************************
// register offsets and fields
// ***********************************************************
`define SD_REG_CFG 8'h00
`define SD_REG_CMD 8'h04
`define SD_REG_ADDR 8'h08
`define SD_REG_WDATA 8'h0c
`define SD_REG_RDATA 8'h10
`define SD_REG_STATUS 8'h14
`define SD_CFG_RST 5'h00
`define SD_CFG_IL 3
`define SD_CFG_SW 4
`define SD_REQ_GO 0
`define SD_REQ_DIR 1
`define SD_REQ_SRE 2
`define SD_REQ_SRX 3
`define SD_REQ_PDE 4
`define SD_REQ_PDX 5
`define SD_REQ_MRS 6
`define SD_REQ_MASK 7'h7d

`endif

/* logic/sdmr_pkg.sv */
package sdmr_pkg;
    // ***********************************************************
    // controller states
    // ***********************************************************
    typedef enum logic [3:0] {
        st_pwrup,
        st_ipre,
        st_iref,
        st_mrs,
        st_idle,
        st_wait,
        st_ref,
        st_rw,
        st_self,
        st_pd
    } sdmr_state_type;
endpackage : sdmr_pkg

/* logic/sdmr_timer.sv */
`timescale 1ns/1ns
`default_nettype none
module sdmr_timer (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic load,
    input wire logic [13:0] load_val,
    output logic zero
);
    logic [13:0] count_r;
    logic [13:0] count_nxt;

    // load wins, otherwise count down and rest at zero
    assign zero = (count_r == 14'h0);
    assign count_nxt = load ? load_val :
                       (zero ? count_r : count_r - 14'h1);

    // counter flop
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            count_r <= 14'h0;
        else
            count_r <= count_nxt;
    end
endmodule : sdmr_timer
`default_nettype wire

/* verif/sdmr_mem_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// memory device model
// ****
module sdmr_mem_model (
    input wire logic clk,
    input wire logic cke,
    input wire logic [3:0] cmd,
    input wire logic [11:0] addr,
    input wire logic [1:0] ba,
    input wire logic dqm,
    input wire logic [15:0] dq_out,
    input wire logic dq_oe,
    output logic [15:0] dq_in = 16'h0,
    output logic [11:0] mode_r,
    output logic [7:0] fault_r = 8'h00,
    output logic [7:0] ref_r = 8'h00
);
    logic [15:0] mem [0:1023];
    logic [3:0] open_r = 4'h0, rcnt = 4'h0, gap = 4'h0;
    logic [9:0] col;
    logic [7:0] msk;
    logic cke_q = 1'b0, dqm_q = 1'b0;
    logic nop, rsv;
    // deselect acts as no-operation; beat mask; reserved mode bits
    assign nop = cmd[3] | (cmd == 4'h7);
    assign msk = (8'h01 << mode_r[1:0]) - 8'h01;
    assign rsv = |{ba, addr[11:10], addr[8:7]};
    // column of beat i in the programmed order
    function automatic logic [9:0] col_at(input logic [3:0] i);
        if (mode_r[3])
            return {col[9:8], col[7:0] ^ {4'h0, i}};
        return {col[9:8], (col[7:0] & ~msk) | ((col[7:0] + {4'h0, i}) & msk)};
    endfunction : col_at
    // commands act only while the internal clock runs
    always @(posedge clk)
    begin
        cke_q <= cke;
        dqm_q <= dqm;
        gap <= gap - {3'h0, gap != 4'h0};
        if (!nop && (gap != 4'h0 || (cke && !cke_q)))
            fault_r <= fault_r + 8'h01;
        if (cke_q)
        begin
            rcnt <= rcnt - {3'h0, rcnt != 4'h0};
            if (rcnt == 4'h2)
                dq_in <= dqm_q ? ~mem[col] : mem[col];
            else if (rcnt == 4'h1)
                dq_in <= ~dq_in; // released bus, no stale word
            case (nop ? 4'h7 : cmd)
                4'h3: open_r[ba] <= 1'b1;
                4'h2: open_r <= addr[10] ? 4'h0 : open_r & ~(4'h1 << ba);
                4'h5, 4'h4:
                begin
                    col = {ba, addr[7:0]};
                    open_r[ba] <= open_r[ba] & ~addr[10];
                    if (cmd[0])
                        rcnt <= (mode_r[6:4] == 3'h2) ? 4'h2 : 4'h3;
                    else
                    begin
                        if (!dq_oe)
                            fault_r <= fault_r + 8'h01; // undriven write beat
                        for (int i = 0; i <= (mode_r[9] ? 0 : msk); i++)
                            if (!dqm)
                                mem[col_at(i[3:0])] <= dq_out;
                    end
                end
                4'h1:
                begin
                    if (open_r != 4'h0)
                        fault_r <= fault_r + 8'h01;
                    ref_r <= ref_r + {7'h0, cke};
                    gap <= 4'h4;
                end
                4'h0:
                begin
                    if (open_r != 4'h0 || rsv)
                        fault_r <= fault_r + 8'h01;
                    mode_r <= addr;
                end
                default: ;
            endcase
        end
    end
endmodule : sdmr_mem_model
`default_nettype wire

/* verif/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// bench
// ****
module tb_top;
    logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, ref_r, r0, fault_r;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rv, v;
    logic [31:0] seed = 32'hbeef;
    logic sd_cke, sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n, sd_dqm, sd_dq_oe;
    logic [11:0] sd_addr, mode_r;
    logic [1:0] sd_ba;
    logic [15:0] sd_dq_out, sd_dq_in;
    int err_total = 0;
    int n_compared = 0;
    // clock
    always #10 clk = ~clk;
    // controller and memory
    sdmr_ctrl #(.PWRUP_CYC(20)) DUT (.clk(clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sd_cke(sd_cke),
        .sd_cs_n(sd_cs_n), .sd_ras_n(sd_ras_n), .sd_cas_n(sd_cas_n),
        .sd_we_n(sd_we_n), .sd_addr(sd_addr), .sd_ba(sd_ba),
        .sd_dqm(sd_dqm), .sd_dq_out(sd_dq_out), .sd_dq_oe(sd_dq_oe),
        .sd_dq_in(sd_dq_in));
    sdmr_mem_model u_mem (.clk(clk), .cke(sd_cke),
        .cmd({sd_cs_n, sd_ras_n, sd_cas_n, sd_we_n}), .addr(sd_addr),
        .ba(sd_ba), .dqm(sd_dqm), .dq_out(sd_dq_out), .dq_oe(sd_dq_oe),
        .dq_in(sd_dq_in),
        .mode_r(mode_r), .fault_r(fault_r), .ref_r(ref_r));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    function automatic logic [31:0] mode_exp(input logic [4:0] c);
        return {20'h0, 2'h0, c[4], 2'h0, 3'h2, c[3], 1'b0, c[1:0]};
    endfunction : mode_exp
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : check
    // one register cycle, read data taken in the cycle after
    task automatic bus(input logic w, input logic [7:0] ad,
        input logic [31:0] wd);
        @(posedge clk);
        reg_addr <= ad;
        reg_wdata <= wd;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask : bus
    task automatic wait_st(input int b, input logic val);
        for (int i = 0; i < 3000; i++)
        begin
            bus(1'b0, 8'h14, 32'h0);
            if (rv[b] === val)
                return;
        end
        check({31'h0, rv[b]}, {31'h0, val});
    endtask : wait_st
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : stop_test
    // reset, then the scenarios in order
    initial
    begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        wait_st(0, 1'b1);
        for (int k = 0; k < 4; k++)
        begin
            seed = xs(seed);
            v = (k == 0) ? 32'h1f : (k == 1) ? 32'h0b : seed & 32'h1f;
            bus(1'b1, 8'h00, v);
            bus(1'b0, 8'h00, 32'h0);
            check(rv, v);
            bus(1'b1, 8'h04, 32'h40);
            repeat (40) @(posedge clk);
            check({20'h0, mode_r}, mode_exp(v[4:0]));
            for (int j = 0; j < 2; j++)
            begin
                seed = xs(seed);
                bus(1'b1, 8'h08, seed & 32'h3fffff);
                seed = xs(seed);
                bus(1'b1, 8'h0c, seed);
                bus(1'b1, 8'h04, 32'h03);
                repeat (40) @(posedge clk);
                bus(1'b1, 8'h04, 32'h01);
                wait_st(4, 1'b1);
                bus(1'b0, 8'h10, 32'h0);
                check(rv, seed & 32'hffff);
            end
            $display("mode %h done", v[4:0]);
        end
        bus(1'b0, 8'h20, 32'h0);
        check(rv, 32'h0);
        for (int m = 0; m < 2; m++)
        begin
            bus(1'b1, 8'h04, m ? 32'h04 : 32'h10);
            wait_st(m ? 2 : 3, 1'b1);
            check({31'h0, sd_cke}, 32'h0);
            bus(1'b1, 8'h04, m ? 32'h08 : 32'h20);
            wait_st(m ? 2 : 3, 1'b0);
            check({31'h0, sd_cke}, 32'h1);
        end
        $display("low power done");
        r0 = ref_r;
        repeat (2400) @(posedge clk);
        check({31'h0, ref_r - r0 > 8'h02}, 32'h1);
        check({24'h0, fault_r}, 32'h0);
        $display("refresh done");
        stop_test;
    end
    // watchdog
    initial
    begin
        #400000;
        err_total++;
        stop_test;
    end
endmodule : tb_top
`default_nettype wire
